// >>> sbc_supervisor.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// RULE_01 - Power-up enters fail-safe mode and waits
// RULE_02 - Mode pin high enters normal mode
// RULE_03 - Normal mode copies transmit and bus levels
// RULE_04 - No trigger: reset after lead time
// RULE_05 - Reset output combines watchdog and undervoltage
// RULE_06 - Trigger outside open window causes reset
// RULE_07 - Valid triggers keep reset released
// RULE_08 - Wake from bus, local or ignition
// RULE_09 - Inhibit output follows operating mode
// RULE_10 - Falling trigger edge is the trigger event
// RULE_11 - Watchdog off in silent or sleep
// RULE_12 - Transceiver path only in normal mode
// RULE_13 - Dominant time-out forces transmit recessive
// RULE_14 - Closed-window trigger causes watchdog reset
module sbc_supervisor #(
    parameter int unsigned LEAD_CYC = sbc_pkg::LEAD_CYCLES,
    parameter int unsigned UV_CYC = sbc_pkg::UV_CYCLES,
    parameter int unsigned CLOSED_CYC = sbc_pkg::CLOSED_CYCLES,
    parameter int unsigned OPEN_CYC = sbc_pkg::OPEN_CYCLES,
    parameter int unsigned WDRST_CYC = sbc_pkg::WD_RESET_CYCLES,
    parameter int unsigned DOM_CYC = sbc_pkg::DOM_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic mode_enable,
    input wire logic sleep_request,
    input wire logic watchdog_trigger_n,
    input wire logic transmit_in,
    input wire logic bus_in,
    input wire logic local_wake_n,
    input wire logic ignition_wake_input,
    input wire logic logic_undervoltage,
    output logic bus_drive_low,
    output logic receive_out,
    output logic system_reset_n_o,
    output logic system_reset_n_oe,
    output logic inhibit_output,
    output logic wake_event,
    output sbc_pkg::mode_t mode_out
);
    import sbc_pkg::*;

    typedef enum logic [1:0] {WD_OFF, WD_LEAD, WD_CLOSED, WD_OPEN} wd_t;

    // The watchdog only runs in the modes in which the host is expected to be alive.
    function automatic logic wd_runs(input mode_t mode_v);
        return (mode_v == MODE_FAILSAFE) || (mode_v == MODE_NORMAL);
    endfunction : wd_runs

    // Two-stage synchronisers for all pin inputs except logic_undervoltage, which is used directly.
    localparam int unsigned NSYNC = 7;
    // Reset the synchronisers to the idle level of each pin, so that no false request or edge follows reset.
    localparam logic [NSYNC-1:0] PIN_IDLE = 7'h1E;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] s1_q, s2_q, s1_d;
    assign pins = {mode_enable, sleep_request, watchdog_trigger_n, transmit_in,
                   bus_in, local_wake_n, ignition_wake_input};
    always_comb begin
        s1_d = pins;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_q <= PIN_IDLE;
            s2_q <= PIN_IDLE;
        end else begin
            s1_q <= s1_d;
            s2_q <= s1_q;
        end
    end
    logic en_s, slp_s, trg_s, txd_s, bus_s, lwake_s, ign_s;
    assign {en_s, slp_s, trg_s, txd_s, bus_s, lwake_s, ign_s} = s2_q;

    mode_t mode_q, mode_d;
    wd_t wd_q, wd_d;
    logic [31:0] wcnt_q, wcnt_d;
    logic [31:0] rcnt_q, rcnt_d;
    logic [31:0] ucnt_q, ucnt_d;
    logic [31:0] dcnt_q, dcnt_d;
    logic trg_prev_q, trg_prev_d;
    logic bus_prev_q, bus_prev_d;
    logic drv_q, drv_d, rxo_q, rxo_d, rst_oe_q, rst_oe_d, inh_q, inh_d, wake_q, wake_d;
    logic trig_fall, bus_fall, wake_any, wd_fault, reset_active;

    // Only a falling edge counts, so a trigger pin held low gives one event and not many.
    assign trig_fall = trg_prev_q & ~trg_s; // [RULE_10]
    assign bus_fall = bus_prev_q & ~bus_s;
    assign wake_any = bus_fall | ~lwake_s | ign_s; // [RULE_08]
    assign reset_active = (rcnt_q != 32'h0) || (ucnt_q != 32'h0);

    // Mode and watchdog sequencing.
    always_comb begin
        mode_d = mode_q;
        wd_d = wd_q;
        wcnt_d = wcnt_q;
        rcnt_d = (rcnt_q != 32'h0) ? rcnt_q - 32'h1 : 32'h0;
        wd_fault = 1'b0;
        wake_d = 1'b0;
        trg_prev_d = trg_s;
        bus_prev_d = bus_s;
        case (mode_q)
            MODE_FAILSAFE: if (en_s) mode_d = MODE_NORMAL; // [RULE_01] [RULE_02]
            MODE_NORMAL: if (!en_s) mode_d = slp_s ? MODE_SLEEP : MODE_SILENT;
            MODE_SILENT, MODE_SLEEP: begin
                if (wake_any) begin
                    wake_d = 1'b1;
                    mode_d = MODE_FAILSAFE;
                end else if (en_s) begin
                    mode_d = MODE_NORMAL;
                end
            end
            default: mode_d = MODE_FAILSAFE;
        endcase
        case (wd_q)
            WD_OFF: if (wd_runs(mode_q)) begin
                wd_d = WD_LEAD;
                wcnt_d = 32'h0;
            end
            WD_LEAD: begin
                wcnt_d = wcnt_q + 32'h1;
                if (trig_fall) begin
                    wd_d = WD_CLOSED;
                    wcnt_d = 32'h0;
                end else if (wcnt_q >= LEAD_CYC - 1) begin
                    wd_fault = 1'b1; // [RULE_04]
                end
            end
            WD_CLOSED: begin
                wcnt_d = wcnt_q + 32'h1;
                if (trig_fall) begin
                    wd_fault = 1'b1; // [RULE_14] [RULE_06]
                end else if (wcnt_q >= CLOSED_CYC - 1) begin
                    wd_d = WD_OPEN;
                    wcnt_d = 32'h0;
                end
            end
            WD_OPEN: begin
                wcnt_d = wcnt_q + 32'h1;
                if (trig_fall) begin
                    wd_d = WD_CLOSED; // [RULE_07]
                    wcnt_d = 32'h0;
                end else if (wcnt_q >= OPEN_CYC - 1) begin
                    wd_fault = 1'b1; // [RULE_06]
                end
            end
            default: wd_d = WD_OFF;
        endcase
        // A fault restarts the lead time as the reset pulse starts, so the host has the lead time less the reset pulse to recover after its reset.
        if (wd_fault) begin
            rcnt_d = WDRST_CYC;
            wd_d = WD_LEAD;
            wcnt_d = 32'h0;
        end
        if (!wd_runs(mode_q)) begin
            wd_d = WD_OFF; // [RULE_11]
            wcnt_d = 32'h0;
        end
    end

    // Undervoltage reset stretch; the stretch restarts while the level persists.
    always_comb begin
        ucnt_d = (ucnt_q != 32'h0) ? ucnt_q - 32'h1 : 32'h0;
        if (logic_undervoltage) ucnt_d = UV_CYC; // [RULE_05]
    end

    // Transmit path with dominant time-out.
    // The time-out counts in every mode, so a pin stuck low before normal mode never reaches the bus.
    always_comb begin
        dcnt_d = txd_s ? 32'h0 : ((dcnt_q < DOM_CYC) ? dcnt_q + 32'h1 : dcnt_q);
        drv_d = 1'b0;
        rxo_d = RECESSIVE;
        if (mode_q == MODE_NORMAL) begin // [RULE_12]
            drv_d = ~txd_s && (dcnt_q < DOM_CYC); // [RULE_03] [RULE_13]
            rxo_d = bus_s; // [RULE_03]
        end
        rst_oe_d = reset_active; // [RULE_05]
        inh_d = (mode_q != MODE_SLEEP); // [RULE_09]
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= MODE_FAILSAFE;
            wd_q <= WD_OFF;
            wcnt_q <= 32'h0;
            rcnt_q <= 32'h0;
            ucnt_q <= 32'h0;
            dcnt_q <= 32'h0;
            trg_prev_q <= 1'b1;
            bus_prev_q <= 1'b1;
            drv_q <= 1'b0;
            rxo_q <= 1'b1;
            rst_oe_q <= 1'b0;
            inh_q <= 1'b1;
            wake_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            wd_q <= wd_d;
            wcnt_q <= wcnt_d;
            rcnt_q <= rcnt_d;
            ucnt_q <= ucnt_d;
            dcnt_q <= dcnt_d;
            trg_prev_q <= trg_prev_d;
            bus_prev_q <= bus_prev_d;
            drv_q <= drv_d;
            rxo_q <= rxo_d;
            rst_oe_q <= rst_oe_d;
            inh_q <= inh_d;
            wake_q <= wake_d;
        end
    end

    assign bus_drive_low = drv_q;
    assign receive_out = rxo_q;
    assign system_reset_n_o = RESET_ACTIVE;
    assign system_reset_n_oe = rst_oe_q;
    assign inhibit_output = inh_q;
    assign wake_event = wake_q;
    assign mode_out = mode_q;
endmodule : sbc_supervisor

`default_nettype wire

// >>> sbc_pkg.sv
package sbc_pkg;
    // Mode set of the basis chip.
    typedef enum logic [1:0] {
        MODE_FAILSAFE,
        MODE_NORMAL,
        MODE_SILENT,
        MODE_SLEEP
    } mode_t;

    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned LEAD_TIME_MS = 155;
    localparam int unsigned UV_RESET_MS = 4;
    localparam int unsigned CLOSED_WIN_MS = 8;
    localparam int unsigned OPEN_WIN_MS = 20;
    localparam int unsigned WD_RESET_US = 4000;
    localparam int unsigned DOM_TIMEOUT_US = 9000;

    localparam int unsigned LEAD_CYCLES = LEAD_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned UV_CYCLES = UV_RESET_MS * 1000 * CLK_MHZ;
    localparam int unsigned CLOSED_CYCLES = CLOSED_WIN_MS * 1000 * CLK_MHZ;
    localparam int unsigned OPEN_CYCLES = OPEN_WIN_MS * 1000 * CLK_MHZ;
    localparam int unsigned WD_RESET_CYCLES = WD_RESET_US * CLK_MHZ;
    localparam int unsigned DOM_CYCLES = DOM_TIMEOUT_US * CLK_MHZ;

    localparam logic RESET_ACTIVE = 1'b0;
    localparam logic RECESSIVE = 1'b1;
endpackage : sbc_pkg

// >>> host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] period,
    output logic watchdog_trigger_n
);
    int n = 0;
    initial watchdog_trigger_n = 1'b1;
    // A period of zero stops triggering, so the bench can starve the watchdog.
    always @(negedge ref_clk) begin
        n = (period == 8'h00 || n >= period) ? 0 : n + 1;
        watchdog_trigger_n <= !(period != 8'h00 && n == 0);
    end
endmodule : host_model
`default_nettype wire

// >>> sbc_supervisor_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sbc_supervisor_sva
    import sbc_pkg::*;
#(
    parameter int unsigned DOM_CYC = DOM_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic transmit_in,
    input wire logic bus_in,
    input wire logic logic_undervoltage,
    input wire logic bus_drive_low,
    input wire logic receive_out,
    input wire logic system_reset_n_o,
    input wire logic system_reset_n_oe,
    input wire logic inhibit_output,
    input wire logic wake_event,
    input wire mode_t mode_out
);
    logic [15:0] low_q, low_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Counting the raw pin in every mode keeps this count ahead of the design's synchronised one.
    always_comb begin
        low_d = transmit_in ? 16'h0000 : ((low_q == 16'hFFFF) ? low_q : low_q + 16'h0001);
    end
    always_ff @(posedge ref_clk) begin
        low_q <= reset ? 16'h0000 : low_d;
    end
    fs_reset_a: assert property ($fell(reset) |-> mode_out == MODE_FAILSAFE)
        else $error("mode not failsafe after reset");
    path_off_a: assert property ((mode_out != MODE_NORMAL)[*3]
        |-> $past(receive_out) && !$past(bus_drive_low)) else $error("path live outside normal");
    rx_copy_a: assert property ((mode_out == MODE_NORMAL && $stable(bus_in))[*6]
        |-> receive_out == bus_in) else $error("receive output wrong");
    tx_copy_a: assert property ((mode_out == MODE_NORMAL && $stable(transmit_in))[*6]
        ##0 (low_q < DOM_CYC) |-> bus_drive_low == !transmit_in) else $error("bus drive wrong");
    tx_dom_a: assert property (low_q > DOM_CYC + 8 |-> !bus_drive_low)
        else $error("dominant time-out missed");
    wd_pulse_a: assert property ($rose(system_reset_n_oe) |-> system_reset_n_oe[*8])
        else $error("reset pulse too short");
    uv_reset_a: assert property (logic_undervoltage |-> ##[1:2] system_reset_n_oe)
        else $error("undervoltage reset missing");
    open_drain_a: assert property (system_reset_n_o == RESET_ACTIVE)
        else $error("reset pin drives high");
    inh_mode_a: assert property ($stable(mode_out) |-> inhibit_output == (mode_out != MODE_SLEEP))
        else $error("inhibit output wrong");
    wake_fs_a: assert property (wake_event |=> !wake_event && mode_out == MODE_FAILSAFE)
        else $error("wake pulse wrong");
    cover property ($rose(system_reset_n_oe));
    cover property (wake_event);
    cover property (mode_out == MODE_SLEEP);
endmodule : sbc_supervisor_sva
bind sbc_supervisor sbc_supervisor_sva #(.DOM_CYC(DOM_CYC)) sva (.*);
`default_nettype wire

// >>> system_basis_chip_mode_and_window_watchdog_tb.sv
`timescale 1ns/100ps
`default_nettype none
module system_basis_chip_mode_and_window_watchdog_tb;
    import sbc_pkg::*;
    logic ref_clk = 0, reset = 1, mode_enable = 0, sleep_request = 0, transmit_in = 0, bus_in = 0;
    logic local_wake_n = 1, ignition_wake_input = 0, logic_undervoltage = 0, watchdog_trigger_n;
    logic bus_drive_low, receive_out, system_reset_n_oe, inhibit_output, wake_event;
    mode_t mode_out;
    logic [7:0] period = 8'h00;
    int n_errors = 0, num_checks = 0, cyc = 0;
    initial forever #2 ref_clk = ~ref_clk;
    host_model host (.ref_clk, .period, .watchdog_trigger_n);
    localparam int T_LEAD = 200;
    localparam int T_UV = 50;
    localparam int T_CLOSED = 20;
    localparam int T_OPEN = 40;
    localparam int T_WDRST = 10;
    localparam int T_DOM = 60;
    sbc_supervisor #(.LEAD_CYC(T_LEAD), .UV_CYC(T_UV), .CLOSED_CYC(T_CLOSED), .OPEN_CYC(T_OPEN), .WDRST_CYC(T_WDRST),
        .DOM_CYC(T_DOM)) dut (
        .ref_clk, .reset, .mode_enable, .sleep_request, .watchdog_trigger_n, .transmit_in, .bus_in,
        .local_wake_n, .ignition_wake_input, .logic_undervoltage, .bus_drive_low, .receive_out,
        .system_reset_n_o(), .system_reset_n_oe, .inhibit_output, .wake_event, .mode_out);
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic wait_rst(input int lim, output int c);
        for (c = 0; c < lim && system_reset_n_oe !== 1'b1; c++) tick(1);
    endtask : wait_rst
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        int c;
        tick(16);
        reset = 0;
        tick(1);
        chk({mode_out, inhibit_output, receive_out}, 4'h3);
        chk({3'h0, bus_drive_low}, 4'h0);
        wait_rst(300, c);
        chk({3'h0, c > T_LEAD - 5 && c < T_LEAD + 12}, 4'h1);
        tick(8);
        chk({3'h0, system_reset_n_oe}, 4'h1);
        transmit_in = 1;
        bus_in = 1;
        tick(3);
        chk({3'h0, system_reset_n_oe}, 4'h0);
        period = 8'h1E;
        mode_enable = 1;
        tick(5);
        chk(mode_out, MODE_NORMAL);
        bus_in = 0;
        transmit_in = 0;
        tick(6);
        chk({2'h0, receive_out, bus_drive_low}, 4'h1);
        tick(70);
        chk({3'h0, bus_drive_low}, 4'h0);
        transmit_in = 1;
        bus_in = 1;
        tick(6);
        chk({2'h0, receive_out, bus_drive_low}, 4'h2);
        wait_rst(300, c);
        chk({3'h0, c == 300}, 4'h1);
        // Triggering too often lands an edge in the closed window.
        period = 8'h0A;
        wait_rst(40, c);
        chk({3'h0, c < 40}, 4'h1);
        period = 8'h1E;
        tick(100);
        period = 8'h00;
        wait_rst(100, c);
        chk({3'h0, c < 100}, 4'h1);
        period = 8'h1E;
        tick(20);
        logic_undervoltage = 1;
        tick(3);
        chk({3'h0, system_reset_n_oe}, 4'h1);
        logic_undervoltage = 0;
        tick(40);
        chk({3'h0, system_reset_n_oe}, 4'h1);
        tick(30);
        chk({3'h0, system_reset_n_oe}, 4'h0);
        for (int i = 0; i < 3; i++) begin
            sleep_request = (i == 0);
            mode_enable = 0;
            tick(5);
            chk({mode_out, 1'b0, inhibit_output}, {i == 0 ? MODE_SLEEP : MODE_SILENT, 1'b0, i != 0});
            if (i == 0) begin
                period = 8'h00;
                tick(250);
                chk({3'h0, system_reset_n_oe}, 4'h0);
            end
            ignition_wake_input = (i == 0);
            local_wake_n = (i != 1);
            bus_in = (i != 2);
            for (c = 0; c < 10 && wake_event !== 1'b1; c++) tick(1);
            chk({3'h0, c < 10}, 4'h1);
            tick(2);
            chk(mode_out, MODE_FAILSAFE);
            ignition_wake_input = 0;
            local_wake_n = 1;
            bus_in = 1;
            period = 8'h1E;
            mode_enable = 1;
            tick(40);
        end
        tally_and_finish();
    end
endmodule : system_basis_chip_mode_and_window_watchdog_tb
`default_nettype wire
